// [core/mrx_pkg.sv]
// register map, field layout and types of the receive path of the 4-level fsk modem
// assumes one system clock; the host reaches every register over the serial register port
package mrx_pkg;
    // --------------------------------------------------------------
    // register addresses (8-bit address phase)
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD_FIFO = 8'h48;
    localparam logic [7:0] ADDR_RX_FIFO = 8'h4C;
    localparam logic [7:0] ADDR_FIFO_CTL = 8'h50;
    localparam logic [7:0] ADDR_RX_TRACK = 8'h66;
    localparam logic [7:0] ADDR_MODE = 8'h6B;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h6C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h7E;

    // --------------------------------------------------------------
    // serial framing
    // --------------------------------------------------------------
    localparam logic [4:0] SER_ADDR_LAST = 5'h07;
    localparam logic [4:0] SER_DATA_FIRST = 5'h08;
    localparam logic [4:0] SER_DATA_LAST = 5'h17;
    localparam logic [4:0] SER_FRAME_END = 5'h18;

    // --------------------------------------------------------------
    // fields and values
    // --------------------------------------------------------------
    localparam int FIFO_FLUSH_BIT = 15;
    localparam logic [7:0] CMD_BLOCK_RX_OP = 8'h14;
    localparam logic [1:0] BLOCK_LAST_BYTE = 2'h3;
    localparam logic [1:0] TRK_AUTO = 2'h3;
    localparam int TRK_DC_LSB = 0;
    localparam int TRK_TIM_LSB = 4;
    localparam logic [3:0] MODE_RX = 4'h1;
    localparam int STAT_CMD_DONE = 8;
    localparam int STAT_OVERFLOW = 7;
    localparam int STAT_SYNC = 6;
    localparam int MASK_GLOBAL = 15;
    localparam logic [15:0] REG_RESET = 16'h0000;

    // --------------------------------------------------------------
    // frame sync and receive buffer
    // --------------------------------------------------------------
    localparam int SYNC_LEN = 24;
    localparam logic [23:0] SYNC_FS1 = 24'h5A3C96;
    localparam int RXF_AW = 4;
    localparam logic [RXF_AW:0] RXF_DEPTH = 5'h10;

    typedef enum logic [1:0] {MRX_IDLE, MRX_SEARCH, MRX_DATA} mrx_state_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } mrx_ser_in_t;

    typedef struct packed {
        logic valid;
        logic bit_val;
    } mrx_demod_t;
endpackage

// [core/mrx_core.sv]
// receive path of the 4-level fsk modem: serial register port, sync search, byte fifo, irq
// assumes serial pins and demodulated bits are synchronous to clk_sys_i
// Behaviour
// - flush pattern in fifo control empties the command fifo before reception
// - block command delivers bytes in fours after sync, repeating until mode change
// - tracking value enables automatic dc offset and symbol timing tracking
// - receive start searches first sync; data offered only after detection
// - command done flag set when four payload bytes are ready
// - mode write while receiving stops or restarts the sync search
// - status read clears all flags after its address phase
// - events reach low-active irq only when masked in, gated by bit 15
`timescale 1ns/10ps
module mrx_core (
    input wire logic clk_sys_i,                // 25 MHz system clock
    input wire logic reset_n_i,                // async reset, low active
    input wire mrx_pkg::mrx_ser_in_t ser_i,    // serial port select, clock, data in
    output logic ser_miso_o,                   // serial read data
    output logic ser_miso_oe_n_o,              // low while driving read data
    input wire mrx_pkg::mrx_demod_t demod_i,   // demodulated bit stream
    output logic interrupt_out_low_o,          // interrupt request, low active
    output logic dc_track_en_o,                // automatic dc offset tracking
    output logic timing_track_en_o,            // automatic symbol timing tracking
    output logic rx_active_o                   // receive mode running
);
    // --------------------------------------------------------------
    // serial register port
    // --------------------------------------------------------------
    logic sclk_q_reg;
    logic [4:0] bit_cnt_reg;
    logic [15:0] shin_reg, shout_reg;
    logic [7:0] addr_reg, addr_next;
    logic sclk_rise, sclk_fall, addr_done, wr_done, is_read;
    logic [15:0] wr_data, rd_value;

    assign sclk_rise = ~ser_i.cs_n & ser_i.sclk & ~sclk_q_reg;
    assign sclk_fall = ~ser_i.cs_n & ~ser_i.sclk & sclk_q_reg;
    assign addr_next = {shin_reg[6:0], ser_i.mosi};
    assign wr_data = {shin_reg[14:0], ser_i.mosi};
    assign addr_done = sclk_rise && bit_cnt_reg == mrx_pkg::SER_ADDR_LAST;
    assign wr_done = sclk_rise && bit_cnt_reg == mrx_pkg::SER_DATA_LAST && !is_read;
    assign is_read = addr_reg == mrx_pkg::ADDR_RX_FIFO || addr_reg == mrx_pkg::ADDR_IRQ_STAT;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sclk_q_reg <= 1'b0;
            bit_cnt_reg <= 5'h00;
            shin_reg <= mrx_pkg::REG_RESET;
            addr_reg <= 8'h00;
        end
        else
        begin
            sclk_q_reg <= ser_i.sclk;
            if (ser_i.cs_n)
                bit_cnt_reg <= 5'h00;
            else if (sclk_rise && bit_cnt_reg != mrx_pkg::SER_FRAME_END)
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (sclk_rise)
                shin_reg <= wr_data;
            if (addr_done)
                addr_reg <= addr_next;
        end
    end

    // read data loads at the end of the address phase, shifts out on falling sclk
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            shout_reg <= mrx_pkg::REG_RESET;
        else if (addr_done)
            shout_reg <= rd_value;
        else if (sclk_fall && bit_cnt_reg > mrx_pkg::SER_DATA_FIRST)
            shout_reg <= {shout_reg[14:0], 1'b0};
    end

    assign ser_miso_o = shout_reg[15];
    assign ser_miso_oe_n_o = !(!ser_i.cs_n && is_read && bit_cnt_reg >= mrx_pkg::SER_DATA_FIRST);

    // --------------------------------------------------------------
    // control registers
    // --------------------------------------------------------------
    logic [15:0] cmd_reg, track_reg, mask_reg;
    logic cmd_valid_reg, wr_mode;

    assign wr_mode = wr_done && addr_reg == mrx_pkg::ADDR_MODE;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cmd_reg <= mrx_pkg::REG_RESET;
            cmd_valid_reg <= 1'b0;
            track_reg <= mrx_pkg::REG_RESET;
            mask_reg <= mrx_pkg::REG_RESET;
        end
        else if (wr_done)
        begin
            case (addr_reg)
                mrx_pkg::ADDR_CMD_FIFO:
                begin
                    cmd_reg <= wr_data;
                    cmd_valid_reg <= 1'b1;
                end
                mrx_pkg::ADDR_FIFO_CTL:
                    if (wr_data[mrx_pkg::FIFO_FLUSH_BIT])
                        cmd_valid_reg <= 1'b0;
                mrx_pkg::ADDR_RX_TRACK: track_reg <= wr_data;
                mrx_pkg::ADDR_IRQ_MASK: mask_reg <= wr_data;
                default: ;
            endcase
        end
    end

    assign dc_track_en_o = track_reg[mrx_pkg::TRK_DC_LSB +: 2] == mrx_pkg::TRK_AUTO;
    assign timing_track_en_o = track_reg[mrx_pkg::TRK_TIM_LSB +: 2] == mrx_pkg::TRK_AUTO;

    // --------------------------------------------------------------
    // sync search and byte assembly
    // --------------------------------------------------------------
    mrx_pkg::mrx_state_t state_reg;
    logic [mrx_pkg::SYNC_LEN-1:0] sync_sh_reg;
    logic [7:0] byte_sh_reg;
    logic [2:0] bit_pos_reg;
    logic [1:0] blk_cnt_reg;
    logic block_cmd, sync_hit, byte_done, push;

    assign block_cmd = cmd_valid_reg && cmd_reg[15:8] == mrx_pkg::CMD_BLOCK_RX_OP;
    assign sync_hit = state_reg == mrx_pkg::MRX_SEARCH && demod_i.valid
        && {sync_sh_reg[mrx_pkg::SYNC_LEN-2:0], demod_i.bit_val} == mrx_pkg::SYNC_FS1;
    assign byte_done = state_reg == mrx_pkg::MRX_DATA && demod_i.valid && bit_pos_reg == 3'h7;
    assign push = byte_done && block_cmd;
    assign rx_active_o = state_reg != mrx_pkg::MRX_IDLE;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            state_reg <= mrx_pkg::MRX_IDLE;
        else if (wr_mode)
            state_reg <= wr_data[3:0] == mrx_pkg::MODE_RX ? mrx_pkg::MRX_SEARCH
                : mrx_pkg::MRX_IDLE;
        else
        begin
            case (state_reg)
                mrx_pkg::MRX_SEARCH: if (sync_hit) state_reg <= mrx_pkg::MRX_DATA;
                mrx_pkg::MRX_DATA: ;
                default: state_reg <= mrx_pkg::MRX_IDLE;
            endcase
        end
    end

    // a restart clears the old sync history so stale bits cannot fake a match
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sync_sh_reg <= '0;
            byte_sh_reg <= 8'h00;
            bit_pos_reg <= 3'h0;
            blk_cnt_reg <= 2'h0;
        end
        else if (wr_mode || state_reg == mrx_pkg::MRX_IDLE)
        begin
            sync_sh_reg <= '0;
            bit_pos_reg <= 3'h0;
            blk_cnt_reg <= 2'h0;
        end
        else if (demod_i.valid)
        begin
            if (state_reg == mrx_pkg::MRX_SEARCH)
                sync_sh_reg <= {sync_sh_reg[mrx_pkg::SYNC_LEN-2:0], demod_i.bit_val};
            else
            begin
                byte_sh_reg <= {byte_sh_reg[6:0], demod_i.bit_val};
                bit_pos_reg <= bit_pos_reg + 3'h1;
                if (push)
                    blk_cnt_reg <= blk_cnt_reg + 2'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // receive byte fifo
    // --------------------------------------------------------------
    logic [7:0] rxf_mem [0:(1<<mrx_pkg::RXF_AW)-1];
    logic [mrx_pkg::RXF_AW:0] wr_ptr_reg, rd_ptr_reg, rxf_count;
    logic rxf_full, rxf_empty, pop, do_push;

    assign rxf_count = wr_ptr_reg - rd_ptr_reg;
    assign rxf_full = rxf_count == mrx_pkg::RXF_DEPTH;
    assign rxf_empty = rxf_count == '0;
    assign pop = addr_done && addr_next == mrx_pkg::ADDR_RX_FIFO && !rxf_empty;
    assign do_push = push && !rxf_full;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (do_push)
            rxf_mem[wr_ptr_reg[mrx_pkg::RXF_AW-1:0]] <= {byte_sh_reg[6:0], demod_i.bit_val};
    end

    // --------------------------------------------------------------
    // interrupt status and mask
    // --------------------------------------------------------------
    logic [14:0] status_reg, stat_set;
    logic stat_clr, irq_line;

    always_comb
    begin
        stat_set = '0;
        stat_set[mrx_pkg::STAT_CMD_DONE] = do_push && blk_cnt_reg == mrx_pkg::BLOCK_LAST_BYTE;
        stat_set[mrx_pkg::STAT_OVERFLOW] = push && rxf_full;
        stat_set[mrx_pkg::STAT_SYNC] = sync_hit;
    end

    assign stat_clr = addr_done && addr_next == mrx_pkg::ADDR_IRQ_STAT;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            status_reg <= '0;
        else
            status_reg <= (stat_clr ? 15'h0000 : status_reg) | stat_set;
    end

    assign irq_line = mask_reg[mrx_pkg::MASK_GLOBAL] && |(status_reg & mask_reg[14:0]);
    assign interrupt_out_low_o = !irq_line;

    always_comb
    begin
        case (addr_next)
            mrx_pkg::ADDR_IRQ_STAT: rd_value = {irq_line, status_reg};
            mrx_pkg::ADDR_RX_FIFO: rd_value = {8'h00, rxf_mem[rd_ptr_reg[mrx_pkg::RXF_AW-1:0]]};
            default: rd_value = 16'h0000;
        endcase
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_flush_cmd: assert property (wr_done && addr_reg == mrx_pkg::ADDR_FIFO_CTL
        && wr_data[mrx_pkg::FIFO_FLUSH_BIT] |=> !cmd_valid_reg)
        else $error("flush left a command pending");
    a_block_done: assert property (do_push && blk_cnt_reg == mrx_pkg::BLOCK_LAST_BYTE
        |=> status_reg[mrx_pkg::STAT_CMD_DONE] && blk_cnt_reg == 2'h0)
        else $error("fourth byte did not raise done");
    a_track_sel: assert property (wr_done && addr_reg == mrx_pkg::ADDR_RX_TRACK
        && wr_data == 16'h0033 |=> dc_track_en_o && timing_track_en_o)
        else $error("tracking select not applied");
    a_data_after: assert property (push |-> state_reg == mrx_pkg::MRX_DATA
        && $past(state_reg) != mrx_pkg::MRX_IDLE)
        else $error("byte delivered before sync");
    a_rx_start: assert property (wr_mode && wr_data == 16'h0401
        |=> state_reg == mrx_pkg::MRX_SEARCH ##1 !push)
        else $error("receive start did not search");
    a_mode_stop: assert property (wr_mode && wr_data[3:0] != mrx_pkg::MODE_RX
        |=> !rx_active_o && blk_cnt_reg == 2'h0)
        else $error("mode change did not stop reception");
    a_stat_clear: assert property (stat_clr && stat_set == '0 |=> status_reg == '0)
        else $error("status read did not clear flags");
    a_irq_gate: assert property (!mask_reg[mrx_pkg::MASK_GLOBAL] |-> interrupt_out_low_o)
        else $error("irq asserted with global mask off");
    a_fifo_bound: assert property (rxf_count <= mrx_pkg::RXF_DEPTH)
        else $error("receive fifo count above depth");
    a_fifo_order: assert property (pop |=> rd_ptr_reg == $past(rd_ptr_reg) + 1'b1)
        else $error("receive fifo read pointer did not advance");

    c_sync_found: cover property (sync_hit);
    c_block_done: cover property (stat_set[mrx_pkg::STAT_CMD_DONE]);
    c_pop_after_done: cover property (status_reg[mrx_pkg::STAT_CMD_DONE] ##[1:200] pop);
    c_restart: cover property (state_reg == mrx_pkg::MRX_DATA ##1 wr_mode);
endmodule

// [testbench/mrx_host_model.sv]
// host side of the serial register port: framed 24-bit transfers, address then word
// assumes the device samples the pins on the rising edge of clk_sys_i
`timescale 1ns/10ps
module mrx_host_model (
    input wire logic clk_sys_i,          // system clock
    output mrx_pkg::mrx_ser_in_t ser_o,  // select, serial clock, data out
    input wire logic miso_i,             // read data from the device
    input wire logic oe_n_i              // low while the device drives miso
);
    logic oe_seen;

    initial
    begin
        ser_o = 3'b100;
        oe_seen = 1'b1;
    end

    // one sclk level per clock: the device needs each level seen at an edge
    task automatic xfer(input logic [7:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
        logic [23:0] sh;
        sh = {addr, wdata};
        rdata = 16'h0000;
        @(posedge clk_sys_i);
        ser_o.cs_n <= 1'b0;
        for (int i = 0; i < 24; i++)
        begin
            @(posedge clk_sys_i);
            ser_o.sclk <= 1'b1;
            ser_o.mosi <= sh[23 - i];
            @(negedge clk_sys_i);
            if (i >= 8)
                rdata[23 - i] = miso_i;
            if (i == 8)
                oe_seen = oe_n_i;
            @(posedge clk_sys_i);
            ser_o.sclk <= 1'b0;
        end
        @(posedge clk_sys_i);
        ser_o.cs_n <= 1'b1;
        // idle data line must not look like the last bit sent
        ser_o.mosi <= ~sh[0];
    endtask
endmodule

// [testbench/mrx_core_test.sv]
// self-checking bench of the modem receive path, host procedure end to end
// assumes mrx_core and the host model; demodulated bits come from this bench
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module mrx_core_test;
    logic clk_sys_i;
    logic reset_n_i;
    mrx_pkg::mrx_ser_in_t ser;
    mrx_pkg::mrx_demod_t demod;
    logic miso;
    logic oe_n;
    logic irq_n;
    logic dc_en;
    logic tim_en;
    logic rx_act;
    logic [15:0] rd;
    int n_errors;
    int tests_run;
    int cycles;

    mrx_core u_dut (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .ser_i(ser),
        .ser_miso_o(miso),
        .ser_miso_oe_n_o(oe_n),
        .demod_i(demod),
        .interrupt_out_low_o(irq_n),
        .dc_track_en_o(dc_en),
        .timing_track_en_o(tim_en),
        .rx_active_o(rx_act)
    );

    mrx_host_model u_host (
        .clk_sys_i(clk_sys_i),
        .ser_o(ser),
        .miso_i(miso),
        .oe_n_i(oe_n)
    );

    initial
    begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    // the whole run needs about 2500 cycles
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("BAD cycle_limit expected below 20000 seen %0d", cycles);
            final_report;
        end
    end

    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.xfer(a, d, rd);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] exp);
        u_host.xfer(a, 16'h0000, rd);
        `CHK(nm, exp, rd)
    endtask

    // one valid pulse per bit, msb first; data line toggles between bits
    task automatic send(input logic [31:0] w, input int n);
        for (int k = 0; k < n; k++)
            for (int i = 7; i >= 0; i--)
            begin
                @(posedge clk_sys_i);
                demod <= {1'b1, w[31 - 8 * k - 7 + i]};
                @(posedge clk_sys_i);
                demod <= {1'b0, ~w[31 - 8 * k - 7 + i]};
            end
    endtask

    task automatic send_sync;
        send({mrx_pkg::SYNC_FS1, 8'h00}, 3);
    endtask

    task automatic settle;
        repeat (2) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask

    task automatic read_block(input logic [31:0] w);
        for (int k = 0; k < 4; k++)
            rd_chk("rx_byte", mrx_pkg::ADDR_RX_FIFO, {8'h00, w[31 - 8 * k -: 8]});
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic test_reset;
        `CHK("irq_n", 1'b1, irq_n)
        `CHK("dc_en", 1'b0, dc_en)
        `CHK("rx_act", 1'b0, rx_act)
        `CHK("oe_n", 1'b1, oe_n)
        $display("test reset done");
    endtask

    task automatic test_setup;
        wr(mrx_pkg::ADDR_FIFO_CTL, 16'h8000);
        wr(mrx_pkg::ADDR_CMD_FIFO, 16'h1400);
        wr(mrx_pkg::ADDR_RX_TRACK, 16'h0033);
        `CHK("dc_en", 1'b1, dc_en)
        `CHK("tim_en", 1'b1, tim_en)
        wr(mrx_pkg::ADDR_IRQ_MASK, 16'h8100);
        wr(mrx_pkg::ADDR_MODE, 16'h0401);
        `CHK("rx_act", 1'b1, rx_act)
        $display("test setup done");
    endtask

    task automatic test_first_block;
        send(32'h5555_0000, 2);
        send_sync;
        settle;
        `CHK("irq_n", 1'b1, irq_n)
        send(32'hA1B2_C3D4, 4);
        settle;
        `CHK("irq_n", 1'b0, irq_n)
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h8140);
        `CHK("oe_n", 1'b0, u_host.oe_seen)
        `CHK("irq_n", 1'b1, irq_n)
        read_block(32'hA1B2_C3D4);
        $display("test first_block done");
    endtask

    task automatic test_repeat;
        send(32'h1122_3344, 4);
        settle;
        `CHK("irq_n", 1'b0, irq_n)
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h8100);
        read_block(32'h1122_3344);
        $display("test repeat done");
    endtask

    task automatic test_stop;
        wr(mrx_pkg::ADDR_MODE, 16'h0000);
        `CHK("rx_act", 1'b0, rx_act)
        send_sync;
        send(32'h9988_7766, 4);
        settle;
        `CHK("irq_n", 1'b1, irq_n)
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h0000);
        $display("test stop done");
    endtask

    task automatic test_flush;
        wr(mrx_pkg::ADDR_FIFO_CTL, 16'h8000);
        wr(mrx_pkg::ADDR_MODE, 16'h0401);
        `CHK("rx_act", 1'b1, rx_act)
        send_sync;
        send(32'hDEAD_BEEF, 4);
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h0040);
        wr(mrx_pkg::ADDR_CMD_FIFO, 16'h1400);
        wr(mrx_pkg::ADDR_IRQ_MASK, 16'h0100);
        send(32'h0F1E_2D3C, 4);
        settle;
        `CHK("irq_n", 1'b1, irq_n)
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h0100);
        read_block(32'h0F1E_2D3C);
        $display("test flush done");
    endtask

    // restart from the data state: bytes before the new sync must not count
    task automatic test_restart;
        wr(mrx_pkg::ADDR_MODE, 16'h0401);
        send(32'h2468_ACE0, 4);
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h0000);
        send_sync;
        send(32'h1357_9BDF, 4);
        rd_chk("status", mrx_pkg::ADDR_IRQ_STAT, 16'h0140);
        read_block(32'h1357_9BDF);
        $display("test restart done");
    endtask

    task automatic test_unmapped;
        rd_chk("unmapped", 8'h20, 16'h0000);
        `CHK("oe_n", 1'b1, u_host.oe_seen)
        $display("test unmapped done");
    endtask

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        reset_n_i = 1'b0;
        demod = 2'b00;
        n_errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (12) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(negedge clk_sys_i);
        test_reset;
        test_setup;
        test_first_block;
        test_repeat;
        test_stop;
        test_flush;
        test_restart;
        test_unmapped;
        final_report;
    end
endmodule
